// ===== hdl/bcis_pkg.sv
// constants and carrier types for the bridge identification and status bank
package bcis_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_IDENT   = 12'h000;
   localparam logic [11:0] OFF_CMDSTAT = 12'h004;
   localparam logic [11:0] OFF_GPIO_CTL = 12'h214;
   localparam logic [11:0] OFF_GPIO_RD = 12'h218;
   localparam logic [11:0] OFF_GPIO_WR = 12'h21C;
   localparam logic [11:0] OFF_INT_MSG = 12'h220;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h300;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h304;
   // identifier defaults are arbitrary neutral values
   localparam logic [15:0] DEV_ID_RST  = 16'h0001;
   localparam logic [15:0] VEN_ID_RST  = 16'h0001;
   localparam int BIT_DPE  = 31;
   localparam int BIT_SSE  = 30;
   localparam int BIT_RMA  = 29;
   localparam int BIT_RTA  = 28;
   localparam int BIT_STA  = 27;
   localparam int BIT_MDP  = 24;
   localparam int BIT_CAPL = 20;
   localparam int BIT_SYSTEM_ERROR_REPORT_ENABLE = 8;
   localparam int BIT_PARITY_RESPONSE_ENABLE  = 6;
   localparam logic [31:0] CMDSTAT_RST = 32'h0010_0000;
   localparam logic [31:0] CMD_WMASK   = 32'h0000_0140;
   localparam int NUM_EVT = 6;

   typedef struct packed {
      logic poison_rx;
      logic err_msg_tx;
      logic ur_cpl_rx;
      logic ca_cpl_rx;
      logic ca_cpl_tx;
      logic poison_cpl_rx;
      logic poison_wr_tx;
   } bcis_evt_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } bcis_req_type;
endpackage : bcis_pkg

// ===== hdl/bcis_regs.sv
// identification, status and vendor register bank of the bridge
`timescale 1ns/10ps
module bcis_regs (
   input  wire logic               i_mclk,
   input  wire logic               i_nrst,
   input  wire bcis_pkg::bcis_req_type i_req,
   input  wire bcis_pkg::bcis_evt_type i_evt,
   input  wire logic               i_ee_load,
   input  wire logic [15:0]        i_ee_dev_id,
   input  wire logic [15:0]        i_ee_ven_id,
   input  wire logic [31:0]        i_gpio_pins,
   output logic [31:0]             o_rdata,
   output logic                    o_err_report_en,
   output logic [31:0]             o_gpio_ctl,
   output logic [31:0]             o_gpio_out,
   output logic [31:0]             o_int_msg_ctl,
   output logic                    o_irq
);
   import bcis_pkg::*;

   logic [15:0] dev_id_q;
   logic [15:0] ven_id_q;
   logic [31:0] cmd_q;
   logic [31:0] sticky_q;
   logic [31:0] gpio_ctl_q;
   logic [31:0] gpio_wr_q;
   logic [31:0] int_msg_q;
   logic [31:0] pin_s1_q;
   logic [31:0] pin_s2_q;
   logic [NUM_EVT-1:0] irq_stat_q;
   logic [NUM_EVT-1:0] irq_mask_q;
   logic [31:0] set_d;
   logic [31:0] status_rd;
   logic [31:0] rdata_d;
   logic [NUM_EVT-1:0] evt_pulse;
   logic wr_cs;
   logic wr_stat;

   assign wr_cs   = i_req.wr && (i_req.addr == OFF_CMDSTAT);
   assign wr_stat = i_req.wr && (i_req.addr == OFF_IRQ_STAT);

   // identifiers replaced by eeprom load, never by software
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         dev_id_q <= DEV_ID_RST;
         ven_id_q <= VEN_ID_RST;
      end else if (i_ee_load) begin
         dev_id_q <= i_ee_dev_id;
         ven_id_q <= i_ee_ven_id;
      end
   end

   // only the two enables are writable in the command half
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_q <= 32'h0000_0000;
      end else if (wr_cs) begin
         cmd_q <= i_req.wdata & CMD_WMASK;
      end
   end

   always_comb begin
      set_d = 32'h0000_0000;
      set_d[BIT_DPE] = i_evt.poison_rx;
      set_d[BIT_SSE] = i_evt.err_msg_tx && cmd_q[BIT_SYSTEM_ERROR_REPORT_ENABLE];
      set_d[BIT_RMA] = i_evt.ur_cpl_rx;
      set_d[BIT_RTA] = i_evt.ca_cpl_rx;
      set_d[BIT_STA] = i_evt.ca_cpl_tx;
      set_d[BIT_MDP] = cmd_q[BIT_PARITY_RESPONSE_ENABLE]
                       && (i_evt.poison_cpl_rx || i_evt.poison_wr_tx);
   end

   // set wins over a simultaneous write-one clear
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sticky_q <= 32'h0000_0000;
      end else if (wr_cs) begin
         sticky_q <= (sticky_q & ~i_req.wdata) | set_d;
      end else begin
         sticky_q <= sticky_q | set_d;
      end
   end

   // upstream error messages only leave with the enable set
   assign o_err_report_en = cmd_q[BIT_SYSTEM_ERROR_REPORT_ENABLE];

   always_comb begin
      // bits 26:25, 23, 22, 21, 19 and 18:11 stay zero
      status_rd = CMDSTAT_RST | cmd_q;
      status_rd[BIT_DPE] = sticky_q[BIT_DPE];
      status_rd[BIT_SSE] = sticky_q[BIT_SSE];
      status_rd[BIT_RMA] = sticky_q[BIT_RMA];
      status_rd[BIT_RTA] = sticky_q[BIT_RTA];
      status_rd[BIT_STA] = sticky_q[BIT_STA];
      status_rd[BIT_MDP] = sticky_q[BIT_MDP];
   end

   // vendor registers; pins come from outside, so synchronise
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         gpio_ctl_q <= 32'h0000_0000;
         gpio_wr_q  <= 32'h0000_0000;
         int_msg_q  <= 32'h0000_0000;
      end else if (i_req.wr) begin
         case (i_req.addr)
            OFF_GPIO_CTL: gpio_ctl_q <= i_req.wdata;
            OFF_GPIO_WR:  gpio_wr_q  <= i_req.wdata;
            OFF_INT_MSG:  int_msg_q  <= i_req.wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_s1_q <= 32'h0000_0000;
         pin_s2_q <= 32'h0000_0000;
      end else begin
         pin_s1_q <= i_gpio_pins;
         pin_s2_q <= pin_s1_q;
      end
   end

   // interrupt aggregation over the six status events
   assign evt_pulse = {set_d[BIT_DPE], set_d[BIT_SSE], set_d[BIT_RMA],
                       set_d[BIT_RTA], set_d[BIT_STA], set_d[BIT_MDP]};

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat_q <= '0;
      end else if (wr_stat) begin
         irq_stat_q <= (irq_stat_q & ~i_req.wdata[NUM_EVT-1:0]) | evt_pulse;
      end else begin
         irq_stat_q <= irq_stat_q | evt_pulse;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_mask_q <= '0;
      end else if (i_req.wr && (i_req.addr == OFF_IRQ_MASK)) begin
         irq_mask_q <= i_req.wdata[NUM_EVT-1:0];
      end
   end

   assign o_irq = |(irq_stat_q & irq_mask_q);

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (i_req.addr)
         OFF_IDENT:    rdata_d = {dev_id_q, ven_id_q};
         OFF_CMDSTAT:  rdata_d = status_rd;
         OFF_GPIO_CTL: rdata_d = gpio_ctl_q;
         OFF_GPIO_RD:  rdata_d = pin_s2_q;
         OFF_GPIO_WR:  rdata_d = gpio_wr_q;
         OFF_INT_MSG:  rdata_d = int_msg_q;
         OFF_IRQ_STAT: rdata_d = {26'h0, irq_stat_q};
         OFF_IRQ_MASK: rdata_d = {26'h0, irq_mask_q};
         default:      rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_req.rd) begin
         o_rdata <= rdata_d;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   assign o_gpio_ctl    = gpio_ctl_q;
   assign o_gpio_out    = gpio_wr_q;
   assign o_int_msg_ctl = int_msg_q;
endmodule : bcis_regs

// ===== tb/bcis_regs_assertions.sv
// concurrent checks on the identification and status bank
`timescale 1ns/10ps
module bcis_chk (
   input wire logic                   i_mclk,
   input wire logic                   i_nrst,
   input wire bcis_pkg::bcis_req_type i_req,
   input wire bcis_pkg::bcis_evt_type i_evt,
   input wire logic [31:0]            o_rdata,
   input wire logic                   o_err_report_en,
   input wire logic [31:0]            o_gpio_ctl,
   input wire logic [31:0]            o_gpio_out
);
   import bcis_pkg::*;
   logic rd_cs;
   logic wr_cs;
   assign rd_cs = i_req.rd && i_req.addr == OFF_CMDSTAT;
   assign wr_cs = i_req.wr && i_req.addr == OFF_CMDSTAT;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   property p_dpe;
      rd_cs && $past(i_evt.poison_rx) |=> o_rdata[31];
   endproperty
   property p_sse;
      rd_cs && $past(i_evt.err_msg_tx) && $past(o_err_report_en)
         |=> o_rdata[30];
   endproperty
   property p_rma;
      rd_cs && $past(i_evt.ur_cpl_rx) |=> o_rdata[29];
   endproperty
   property p_sta;
      rd_cs && $past(i_evt.ca_cpl_tx) |=> o_rdata[27];
   endproperty
   property p_fix;
      rd_cs |=> o_rdata[26:25] == 2'h0 && o_rdata[23:11] == 13'h0200;
   endproperty
   property p_gct;
      i_req.wr && i_req.addr == OFF_GPIO_CTL
         |=> o_gpio_ctl == $past(i_req.wdata);
   endproperty
   property p_gou;
      i_req.wr && i_req.addr == OFF_GPIO_WR
         |=> o_gpio_out == $past(i_req.wdata);
   endproperty
   property p_ser; wr_cs |=> o_err_report_en == $past(i_req.wdata[8]); endproperty
   a_dpe: assert property (p_dpe) else $error("dpe");
   a_sse: assert property (p_sse) else $error("sse");
   a_rma: assert property (p_rma) else $error("rma");
   a_sta: assert property (p_sta) else $error("sta");
   a_fix: assert property (p_fix) else $error("fixed bits");
   a_gct: assert property (p_gct) else $error("gpio ctl");
   a_gou: assert property (p_gou) else $error("gpio out");
   a_ser: assert property (p_ser) else $error("system_error_report_enable");
   c_evt: cover property (rd_cs && $past(i_evt.ur_cpl_rx));
   c_ser: cover property (wr_cs && !i_req.wdata[8]);
   c_gct: cover property (i_req.wr && i_req.addr == OFF_GPIO_CTL);
endmodule : bcis_chk
bind bcis_regs bcis_chk bcis_chk_i (.*);

// ===== tb/bcis_rc_model.sv
// link-side source of one-cycle error events
`timescale 1ns/10ps
module bcis_rc_model (
   input  wire logic              i_mclk,
   output bcis_pkg::bcis_evt_type o_evt
);
   initial o_evt = '0;
   // clear is forked so the caller may issue a read at the next edge
   task automatic send(input int k);
      @(posedge i_mclk);
      o_evt <= bcis_pkg::bcis_evt_type'(7'h01 << k);
      fork
         @(posedge i_mclk) o_evt <= '0;
      join_none
   endtask : send
endmodule : bcis_rc_model

// ===== tb/test_bridge_config_id_and_status.sv
// self-checking bench for the identification and status bank
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
   miscompares++; $display("unexpected %s exp %h got %h", n, e, s); end end
module test_bridge_config_id_and_status;
   import bcis_pkg::*;
   logic         i_mclk = 1'b0;
   logic         i_nrst = 1'b0;
   bcis_req_type i_req = '0;
   bcis_evt_type i_evt;
   logic         i_ee_load = 1'b0;
   logic [15:0]  i_ee_dev_id = 16'hA5C3;
   logic [15:0]  i_ee_ven_id = 16'h3C5A;
   logic [31:0]  i_gpio_pins = 32'h5A5A_C3C3;
   logic [31:0]  o_rdata, o_gpio_ctl, o_gpio_out, o_int_msg_ctl, d;
   logic         o_err_report_en, o_irq;
   int           compares = 0;
   int           miscompares = 0;
   always #5 i_mclk = ~i_mclk;
   bcis_regs bcis_regs_i (.*);
   bcis_rc_model bcis_rc_model_i (.i_mclk(i_mclk), .o_evt(i_evt));
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge i_mclk);
      i_req <= '{1'b1, 1'b0, a, v};
      @(posedge i_mclk);
      i_req <= '0;
      #1;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge i_mclk);
      i_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge i_mclk);
      i_req <= '0;
      #1 d = o_rdata;
   endtask : rd
   task automatic final_report;
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic t_reset;
      wr(OFF_IDENT, 32'hFFFF_FFFF);
      rd(OFF_IDENT);
      `CHK("ident", {DEV_ID_RST, VEN_ID_RST}, d)
      rd(OFF_CMDSTAT);
      `CHK("csr", CMDSTAT_RST, d)
      wr(OFF_CMDSTAT, 32'hFFFF_FFFF);
      rd(OFF_CMDSTAT);
      `CHK("csr ro", 32'h0010_0140, d)
   endtask : t_reset
   task automatic t_events;
      int b[7] = '{24, 24, 27, 28, 29, 30, 31};
      bcis_rc_model_i.send(4);
      rd(OFF_IRQ_STAT);
      `CHK("irq masked", {32'h8, 1'b0}, {d, o_irq})
      for (int k = 0; k < 7; k++) begin
         wr(OFF_IRQ_MASK, 32'h3F);
         bcis_rc_model_i.send(k);
         rd(OFF_CMDSTAT);
         `CHK("flag", 2'b11, {d[b[k]], o_irq})
         wr(OFF_CMDSTAT, 32'hFF00_0140);
         wr(OFF_IRQ_STAT, 32'h3F);
         rd(OFF_CMDSTAT);
         `CHK("w1c", 2'b00, {d[b[k]], o_irq})
      end
   endtask : t_events
   task automatic t_gate;
      int g[3] = '{5, 1, 0};
      wr(OFF_CMDSTAT, 32'hFF00_0000);
      `CHK("system_error_report_enable", 1'b0, o_err_report_en)
      for (int i = 0; i < 3; i++) begin
         bcis_rc_model_i.send(g[i]);
         rd(OFF_CMDSTAT);
         `CHK("gated", 2'b00, {d[30], d[24]})
      end
   endtask : t_gate
   task automatic t_misc;
      wr(OFF_GPIO_WR, 32'h9ABC_DEF0);
      `CHK("gpio out", 32'h9ABC_DEF0, o_gpio_out)
      `CHK("gpio ctl", 32'h1234_5678, o_gpio_ctl)
      wr(OFF_INT_MSG, 32'h0F0F_00FF);
      `CHK("msg", 32'h0F0F_00FF, o_int_msg_ctl)
      rd(OFF_GPIO_RD);
      `CHK("pins", i_gpio_pins, d)
      @(posedge i_mclk);
      i_ee_load <= 1'b1;
      @(posedge i_mclk);
      i_ee_load <= 1'b0;
      rd(OFF_IDENT);
      `CHK("ee ident", 32'hA5C3_3C5A, d)
   endtask : t_misc
   initial begin
      #20us;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge i_mclk);
      i_nrst <= 1'b1;
      t_reset();
      t_events();
      t_gate();
      wr(OFF_GPIO_CTL, 32'h1234_5678);
      t_misc();
      final_report();
   end
endmodule : test_bridge_config_id_and_status
